// File: rtl/cbfc_frame_checker.sv
// The address map and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`include "cbfc_defs.svh"
module cbfc_frame_checker
   import cbfc_pkg::*;
#(
   // Arbitrary value
   parameter logic [`CBFC_PART_ID_W-1:0] PART_ID = 20'h5a3c1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Serial configuration pins
   input wire logic streamClk,
   input wire logic streamData,
   input wire logic reprogramRequest,
   // Status pins
   output logic readyStatusLow_n,
   output logic loadDone,
   // Configuration memory write port
   output logic cfgWrEn,
   output logic [`CBFC_ADDR_W-1:0] cfgWrAddr,
   output logic [`CBFC_DATA_BITS-1:0] cfgWrData,
   // AXI4-Lite write channels
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read channels
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   localparam logic [15:0] ID_HDR = `CBFC_ID_HDR;

   function automatic logic isMapped(input logic [7:0] a);
      isMapped = (a == `CBFC_REG_CS) || (a == `CBFC_REG_FRAMES) ||
                 (a == `CBFC_REG_LENGTH) || (a == `CBFC_REG_PARTID);
   endfunction

   logic [2:0] pinSync;
   logic clkPrev_ff;
   logic bitStb;
   logic bitIn;
   logic progPin;
   cbfc_state_t state_ff, nxtState;
   logic [7:0] cnt_ff;
   logic [3:0] window_ff;
   logic [`CBFC_LEN_W-1:0] lengthCount_ff;
   logic [`CBFC_LEN_W-1:0] clkCount_ff;
   logic [1:0] modeRx_ff;
   logic [`CBFC_PART_ID_W-1:0] idRx_ff;
   logic [7:0] csumRx_ff;
   logic [`CBFC_DATA_BITS-1:0] dataBuf_ff;
   logic [`CBFC_ADDR_W-1:0] addrRx_ff;
   logic [`CBFC_ADDR_W-1:0] autoAddr_ff;
   logic [`CBFC_ADDR_W-1:0] framesWritten_ff;
   logic post_ff;
   logic stopBad_ff;
   cbfc_kind_t kind_ff;
   cbfc_mode_t mode_ff;
   cbfc_err_t err_ff, nxtErr;
   logic fault_ff;
   logic wrEn_ff;
   logic [`CBFC_ADDR_W-1:0] wrAddr_ff;
   logic [7:0] csumSum;
   logic csumAcc;
   logic csumClr;
   logic csumPass;
   logic [7:0] hdrIdx;
   logic [7:0] stopLast;
   logic restart;
   logic swReprog;
   logic faultClr;
   logic wrTake;
   logic bvalid_ff;
   logic [1:0] bresp_ff;
   logic rvalid_ff;
   logic [1:0] rresp_ff;
   logic [31:0] rdata_ff;
   logic [31:0] csWord;
   logic [31:0] rdWord;

   // Pin synchronisers
   cbfc_bit_sync u_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .asyncIn({reprogramRequest, streamData, streamClk}),
      .syncOut(pinSync)
   );
   assign bitIn = pinSync[1];
   assign progPin = pinSync[2];

   // One strobe per rising stream clock
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         clkPrev_ff <= 1'b0;
      end else begin
         clkPrev_ff <= pinSync[0];
      end
   end
   assign bitStb = pinSync[0] && !clkPrev_ff;
   assign restart = swReprog || progPin;

   assign hdrIdx = 8'(`CBFC_ID_HDR_LAST - cnt_ff);
   assign stopLast = post_ff ? `CBFC_POST_STOP_LAST : `CBFC_STOP_LAST;

   // Frame parser
   always_comb begin
      nxtState = state_ff;
      nxtErr = ERR_NONE;
      if (bitStb) begin
         unique case (state_ff)
            ST_SEEK: begin
               if ({window_ff[2:0], bitIn} == `CBFC_PREAMBLE) begin
                  nxtState = ST_LEN;
               end
            end
            ST_LEN: begin
               if (cnt_ff == `CBFC_LEN_LAST) begin
                  nxtState = ST_TRAIL;
               end
            end
            ST_TRAIL: begin
               if (!bitIn) begin
                  nxtErr = ERR_ALIGN;
               end else if (cnt_ff == `CBFC_TRAIL_LAST) begin
                  nxtState = ST_IDHDR;
               end
            end
            ST_IDHDR: begin
               if (bitIn != ID_HDR[hdrIdx[3:0]]) begin
                  nxtErr = ERR_ID;
               end else if (cnt_ff == `CBFC_ID_HDR_LAST) begin
                  nxtState = ST_IDBODY;
               end
            end
            ST_IDBODY: begin
               if (cnt_ff == `CBFC_ID_BODY_LAST) begin
                  if ({idRx_ff[`CBFC_PART_ID_W-2:0], bitIn} != PART_ID ||
                      modeRx_ff[1]) begin
                     nxtErr = ERR_ID;
                  end else begin
                     nxtState = ST_CSUM;
                  end
               end
            end
            ST_CSUM: begin
               if (cnt_ff == `CBFC_CSUM_LAST) begin
                  if (!post_ff && {csumRx_ff[6:0], bitIn} != csumSum) begin
                     nxtErr = ERR_CSUM;
                  end else begin
                     nxtState = ST_STOP;
                  end
               end
            end
            ST_STOP: begin
               if (cnt_ff == stopLast) begin
                  nxtState = post_ff ? ST_FINISH : ST_HUNT;
               end
            end
            ST_HUNT: begin
               if (!bitIn) begin
                  nxtState = ST_KIND;
               end
            end
            ST_KIND: begin
               if (stopBad_ff) begin
                  nxtErr = ERR_ALIGN;
               end else begin
                  nxtState = bitIn ? ST_DATA : ST_ADDR;
               end
            end
            ST_DATA: begin
               if (cnt_ff == `CBFC_DATA_LAST) begin
                  nxtState = ST_PAD;
               end
            end
            ST_PAD: begin
               if (cnt_ff == `CBFC_PAD_LAST) begin
                  nxtState = ST_CSUM;
               end
            end
            ST_ADDR: begin
               if (cnt_ff == `CBFC_ADDR_LAST) begin
                  nxtState = ST_CSUM;
               end
            end
            ST_FINISH, ST_DONE, ST_ERROR, ST_SPARE: begin
            end
         endcase
      end
      if (state_ff == ST_FINISH && clkCount_ff >= lengthCount_ff) begin
         nxtState = ST_DONE;
      end
      if (nxtErr != ERR_NONE) begin
         nxtState = ST_ERROR;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst || restart) begin
         state_ff <= ST_SEEK;
         cnt_ff <= 8'h00;
      end else begin
         state_ff <= nxtState;
         if (nxtState != state_ff) begin
            cnt_ff <= 8'h00;
         end else if (bitStb) begin
            cnt_ff <= 8'(cnt_ff + 8'h01);
         end
      end
   end

   // Header fields and load clock count
   always_ff @(posedge clk) begin
      if (sys_rst || restart) begin
         window_ff <= 4'hf;
         lengthCount_ff <= '0;
         clkCount_ff <= '0;
      end else if (bitStb && state_ff != ST_DONE && state_ff != ST_ERROR) begin
         window_ff <= {window_ff[2:0], bitIn};
         clkCount_ff <= `CBFC_LEN_W'(clkCount_ff + 1'b1);
         if (state_ff == ST_LEN) begin
            lengthCount_ff <= {lengthCount_ff[`CBFC_LEN_W-2:0], bitIn};
         end
      end
   end

   // ID frame fields
   always_ff @(posedge clk) begin
      if (sys_rst || restart) begin
         modeRx_ff <= 2'b00;
         idRx_ff <= '0;
         mode_ff <= MODE_AUTO;
      end else if (bitStb && state_ff == ST_IDBODY) begin
         idRx_ff <= {idRx_ff[`CBFC_PART_ID_W-2:0], bitIn};
         if (cnt_ff <= `CBFC_MODE_LAST) begin
            modeRx_ff <= {modeRx_ff[0], bitIn};
         end
         if (cnt_ff == `CBFC_ID_BODY_LAST) begin
            mode_ff <= cbfc_mode_t'(modeRx_ff);
         end
      end
   end

   // Frame payload and trailer capture
   always_ff @(posedge clk) begin
      if (sys_rst || restart) begin
         csumRx_ff <= 8'h00;
         dataBuf_ff <= '0;
         addrRx_ff <= '0;
         post_ff <= 1'b0;
         stopBad_ff <= 1'b0;
         kind_ff <= KIND_ID;
      end else if (bitStb) begin
         if (state_ff == ST_CSUM) begin
            csumRx_ff <= {csumRx_ff[6:0], bitIn};
         end
         if (state_ff == ST_DATA) begin
            dataBuf_ff <= {dataBuf_ff[`CBFC_DATA_BITS-2:0], bitIn};
         end
         if (state_ff == ST_ADDR) begin
            addrRx_ff <= {addrRx_ff[`CBFC_ADDR_W-2:0], bitIn};
            if (cnt_ff == `CBFC_ADDR_LAST) begin
               post_ff <= {addrRx_ff[`CBFC_ADDR_W-2:0], bitIn} ==
                          `CBFC_ADDR_ONES;
            end
         end
         if (state_ff == ST_STOP && !bitIn) begin
            stopBad_ff <= 1'b1;
         end
         if (state_ff == ST_IDHDR) begin
            kind_ff <= KIND_ID;
         end
         if (state_ff == ST_KIND) begin
            stopBad_ff <= 1'b0;
            post_ff <= 1'b0;
            kind_ff <= bitIn ? KIND_DATA : KIND_ADDR;
         end
      end
   end

   // Per-frame checksum
   assign csumClr = bitStb && ((state_ff == ST_HUNT && !bitIn) ||
                    (state_ff == ST_IDHDR && cnt_ff == 8'h00));
   assign csumAcc = csumClr || (bitStb && (state_ff == ST_IDHDR ||
                    state_ff == ST_IDBODY || state_ff == ST_KIND ||
                    state_ff == ST_DATA || state_ff == ST_PAD ||
                    state_ff == ST_ADDR));
   cbfc_checksum u_csum (
      .clk(clk),
      .sys_rst(sys_rst),
      .bitValid(csumAcc),
      .clear(csumClr),
      .bitIn(bitIn),
      .sum(csumSum)
   );
   assign csumPass = bitStb && state_ff == ST_CSUM &&
                     nxtState == ST_STOP && !post_ff;

   // Configuration memory writes
   always_ff @(posedge clk) begin
      if (sys_rst || restart) begin
         wrEn_ff <= 1'b0;
         wrAddr_ff <= '0;
         autoAddr_ff <= '0;
         framesWritten_ff <= '0;
      end else begin
         wrEn_ff <= 1'b0;
         if (csumPass && kind_ff == KIND_DATA && mode_ff == MODE_AUTO &&
             autoAddr_ff < `CBFC_NUM_FRAMES) begin
            wrEn_ff <= 1'b1;
            wrAddr_ff <= autoAddr_ff;
            autoAddr_ff <= `CBFC_ADDR_W'(autoAddr_ff + 1'b1);
            framesWritten_ff <= `CBFC_ADDR_W'(framesWritten_ff + 1'b1);
         end else if (csumPass && kind_ff == KIND_ADDR) begin
            wrEn_ff <= 1'b1;
            wrAddr_ff <= addrRx_ff;
            framesWritten_ff <= `CBFC_ADDR_W'(framesWritten_ff + 1'b1);
         end
      end
   end
   assign cfgWrEn = wrEn_ff;
   assign cfgWrAddr = wrAddr_ff;
   assign cfgWrData = dataBuf_ff;

   // Error type and stray-bit fault
   always_ff @(posedge clk) begin
      if (sys_rst || restart) begin
         err_ff <= ERR_NONE;
      end else if (nxtErr != ERR_NONE) begin
         err_ff <= nxtErr;
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         fault_ff <= 1'b0;
      end else if (bitStb && state_ff == ST_ERROR) begin
         fault_ff <= 1'b1;
      end else if (faultClr) begin
         fault_ff <= 1'b0;
      end
   end
   assign readyStatusLow_n = (state_ff != ST_ERROR);
   assign loadDone = (state_ff == ST_DONE);

   // AXI4-Lite write path
   assign wrTake = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
   assign s_axi_awready = wrTake;
   assign s_axi_wready = wrTake;
   assign swReprog = wrTake && s_axi_awaddr == `CBFC_REG_CS &&
                     s_axi_wstrb[1] && s_axi_wdata[`CBFC_CS_REPROG];
   assign faultClr = wrTake && s_axi_awaddr == `CBFC_REG_CS &&
                     s_axi_wstrb[0] && s_axi_wdata[`CBFC_CS_FAULT];
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         bvalid_ff <= 1'b0;
         bresp_ff <= `CBFC_RESP_OKAY;
      end else if (wrTake) begin
         bvalid_ff <= 1'b1;
         bresp_ff <= isMapped(s_axi_awaddr) ? `CBFC_RESP_OKAY :
                     `CBFC_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_ff <= 1'b0;
      end
   end
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;

   // AXI4-Lite read path
   always_comb begin
      csWord = 32'h0000_0000;
      csWord[`CBFC_CS_DONE] = loadDone;
      csWord[`CBFC_CS_INIT] = readyStatusLow_n;
      csWord[`CBFC_CS_FAULT] = fault_ff;
      csWord[`CBFC_CS_ERR_HI:`CBFC_CS_ERR_LO] = err_ff;
      csWord[`CBFC_CS_MODE] = (mode_ff == MODE_EXPLICIT);
      rdWord = 32'h0000_0000;
      if (s_axi_araddr == `CBFC_REG_CS) begin
         rdWord = csWord;
      end else if (s_axi_araddr == `CBFC_REG_FRAMES) begin
         rdWord = 32'(framesWritten_ff);
      end else if (s_axi_araddr == `CBFC_REG_LENGTH) begin
         rdWord = 32'(lengthCount_ff);
      end else if (s_axi_araddr == `CBFC_REG_PARTID) begin
         rdWord = 32'(idRx_ff);
      end
   end
   assign s_axi_arready = !rvalid_ff;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rvalid_ff <= 1'b0;
         rresp_ff <= `CBFC_RESP_OKAY;
         rdata_ff <= 32'h0000_0000;
      end else if (s_axi_arvalid && !rvalid_ff) begin
         rvalid_ff <= 1'b1;
         rdata_ff <= rdWord;
         rresp_ff <= isMapped(s_axi_araddr) ? `CBFC_RESP_OKAY :
                     `CBFC_RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_ff <= 1'b0;
      end
   end
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rresp = rresp_ff;
   assign s_axi_rdata = rdata_ff;
endmodule // cbfc_frame_checker

// File: rtl/cbfc_defs.svh
`ifndef CBFC_DEFS_SVH
`define CBFC_DEFS_SVH
`define CBFC_PREAMBLE 4'h2
`define CBFC_LEN_W 24
`define CBFC_LEN_LAST 8'd23
`define CBFC_TRAIL_LAST 8'd7
`define CBFC_ID_HDR 16'h5fff
`define CBFC_ID_HDR_LAST 8'd15
`define CBFC_ID_BODY_LAST 8'd63
`define CBFC_MODE_LAST 8'd1
`define CBFC_PART_ID_W 20
`define CBFC_DATA_BITS 232
`define CBFC_DATA_LAST 8'd231
`define CBFC_PAD_LAST 8'd5
`define CBFC_ADDR_W 14
`define CBFC_ADDR_LAST 8'd13
`define CBFC_ADDR_ONES 14'h3fff
`define CBFC_NUM_FRAMES 14'd1240
`define CBFC_CSUM_LAST 8'd7
`define CBFC_STOP_LAST 8'd7
`define CBFC_POST_STOP_LAST 8'd15
`define CBFC_REG_CS 8'h40
`define CBFC_REG_FRAMES 8'h44
`define CBFC_REG_LENGTH 8'h48
`define CBFC_REG_PARTID 8'h4c
`define CBFC_CS_DONE 1
`define CBFC_CS_INIT 2
`define CBFC_CS_FAULT 3
`define CBFC_CS_ERR_LO 9
`define CBFC_CS_ERR_HI 10
`define CBFC_CS_REPROG 12
`define CBFC_CS_MODE 15
`define CBFC_RESP_OKAY 2'b00
`define CBFC_RESP_SLVERR 2'b10
`endif

// File: rtl/cbfc_pkg.sv
package cbfc_pkg;
   typedef enum logic [15:0] {
      ST_SEEK = 16'h0001,
      ST_LEN = 16'h0002,
      ST_TRAIL = 16'h0004,
      ST_IDHDR = 16'h0008,
      ST_IDBODY = 16'h0010,
      ST_CSUM = 16'h0020,
      ST_STOP = 16'h0040,
      ST_HUNT = 16'h0080,
      ST_KIND = 16'h0100,
      ST_DATA = 16'h0200,
      ST_PAD = 16'h0400,
      ST_ADDR = 16'h0800,
      ST_FINISH = 16'h1000,
      ST_DONE = 16'h2000,
      ST_ERROR = 16'h4000,
      ST_SPARE = 16'h8000
   } cbfc_state_t;
   typedef enum logic [1:0] {
      ERR_NONE = 2'b00,
      ERR_ID = 2'b01,
      ERR_ALIGN = 2'b10,
      ERR_CSUM = 2'b11
   } cbfc_err_t;
   typedef enum logic [1:0] {
      KIND_ID = 2'b00,
      KIND_DATA = 2'b01,
      KIND_ADDR = 2'b10
   } cbfc_kind_t;
   typedef enum logic [1:0] {
      MODE_AUTO = 2'b00,
      MODE_EXPLICIT = 2'b01
   } cbfc_mode_t;
endpackage

// File: rtl/cbfc_bit_sync.sv
`timescale 1ns/1ps
module cbfc_bit_sync (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Pin levels in and out
   input wire logic [2:0] asyncIn,
   output logic [2:0] syncOut
);
   genvar i;
   generate
      for (i = 0; i < 3; i++) begin : g_sync
         logic stage1_ff;
         logic stage2_ff;
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               stage1_ff <= 1'b0;
               stage2_ff <= 1'b0;
            end else begin
               stage1_ff <= asyncIn[i];
               stage2_ff <= stage1_ff;
            end
         end
         assign syncOut[i] = stage2_ff;
      end
   endgenerate
endmodule // cbfc_bit_sync

// File: rtl/cbfc_checksum.sv
`timescale 1ns/1ps
module cbfc_checksum (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Bit stream
   input wire logic bitValid,
   input wire logic clear,
   input wire logic bitIn,
   // Running byte-wise parity
   output logic [7:0] sum
);
   logic [2:0] pos_ff;
   logic [7:0] sum_ff;
   logic [2:0] basePos;
   logic [7:0] baseSum;
   assign basePos = clear ? 3'h0 : pos_ff;
   assign baseSum = clear ? 8'h00 : sum_ff;
   // Each bit folds into its column, first bit of a byte at the top
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pos_ff <= 3'h0;
         sum_ff <= 8'h00;
      end else if (bitValid) begin
         pos_ff <= 3'(basePos + 3'h1);
         sum_ff <= baseSum ^ (8'({bitIn, 7'h00}) >> basePos);
      end
   end
   assign sum = sum_ff;
endmodule // cbfc_checksum

// File: tb/cbfc_checker.sv
`timescale 1ns/1ps
module cbfc_checker (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Pins and status
   input wire logic reprogramRequest,
   input wire logic readyStatusLow_n,
   input wire logic loadDone,
   input wire logic cfgWrEn,
   // Register bus
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   sequence s_aw;
      s_axi_awvalid && s_axi_awready;
   endsequence
   sequence s_ar;
      s_axi_arvalid && s_axi_arready;
   endsequence
   a_bvalid_follows: assert property (s_aw |=> s_axi_bvalid)
      else $error("write answer missing");
   a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
   a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("write taken while answering");
   a_rvalid_follows: assert property (s_ar |=> s_axi_rvalid)
      else $error("read answer missing");
   a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped");
   a_unmapped_err: assert property (s_ar and !(s_axi_araddr inside
      {8'h40, 8'h44, 8'h48, 8'h4c}) |=> s_axi_rresp == 2'h2
      && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   a_write_pulse: assert property (cfgWrEn |=> !cfgWrEn)
      else $error("memory write longer than one cycle");
   a_err_quiet: assert property (!readyStatusLow_n
      |-> !cfgWrEn && !loadDone)
      else $error("activity while parked");
   a_err_parks: assert property (!readyStatusLow_n && !s_axi_awready
      && !reprogramRequest
      && !$past(reprogramRequest) && !$past(reprogramRequest, 2)
      && !$past(reprogramRequest, 3) && !$past(reprogramRequest, 4)
      |=> !readyStatusLow_n)
      else $error("left parked state alone");
endmodule // cbfc_checker

bind cbfc_frame_checker cbfc_checker u_chk (.clk(clk), .sys_rst(sys_rst),
   .reprogramRequest(reprogramRequest), .readyStatusLow_n(readyStatusLow_n),
   .loadDone(loadDone), .cfgWrEn(cfgWrEn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready));

// File: tb/cbfc_src.sv
`timescale 1ns/1ps
module cbfc_src (
   // Clock
   input wire logic clk,
   // Stream pins
   output logic sClk,
   output logic sDat
);
   initial begin
      sClk = 1'b0;
      sDat = 1'b1;
   end
   // One bit, held around the rise; clock idles low between bits
   task automatic tx(input logic b);
      sDat <= b;
      repeat (4) @(posedge clk);
      sClk <= 1'b1;
      repeat (4) @(posedge clk);
      sClk <= 1'b0;
      sDat <= ~b;
      @(posedge clk);
   endtask
endmodule // cbfc_src

// File: tb/config_bitstream_frame_checker_test.sv
`timescale 1ns/1ps
module config_bitstream_frame_checker_test
   import cbfc_pkg::*;
;
   localparam logic [19:0] PID = 20'h5a3c1;
   localparam logic [231:0] D1 = {29{8'hc5}};
   localparam logic [231:0] D2 = {29{8'h3a}};
   logic clk, sys_rst, sClk, sDat, rpq, awv, wv, bry, arv, rry;
   logic rdy_n, done, wrEn, awr, wr, bv, arr, rv;
   logic [7:0] awa, ara;
   logic [31:0] wd, rdat, rd;
   logic [3:0] ws;
   logic [1:0] br, rr, rs;
   logic [13:0] wrA;
   logic [231:0] wrD;
   logic q[$];
   logic [13:0] wa[$];
   logic [231:0] wq[$];
   int fs, n_errors, cmp_count, cyc;
   cbfc_frame_checker #(.PART_ID(PID)) u_dut (
      .clk(clk), .sys_rst(sys_rst), .streamClk(sClk), .streamData(sDat),
      .reprogramRequest(rpq), .readyStatusLow_n(rdy_n), .loadDone(done),
      .cfgWrEn(wrEn), .cfgWrAddr(wrA), .cfgWrData(wrD),
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
      .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv),
      .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr),
      .s_axi_rvalid(rv), .s_axi_rready(rry));
   cbfc_src u_src (.clk(clk), .sClk(sClk), .sDat(sDat));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (wrEn === 1'b1) begin
         wa.push_back(wrA);
         wq.push_back(wrD);
      end
      if (cyc == 40000) begin
         n_errors++;
         results();
      end
   end
   task automatic chk(input logic [255:0] got, input logic [255:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic put(input logic [255:0] v, input int n);
      for (int i = n - 1; i >= 0; i--) q.push_back(v[i]);
   endtask
   // Byte-wise checksum, then eight stops
   task automatic fend(input logic bad);
      logic [7:0] c;
      c = 8'h00;
      for (int i = fs; i < q.size(); i++) c[7 - (i - fs) % 8] ^= q[i];
      put(c ^ bad, 8);
      put(8'hff, 8);
      fs = q.size();
   endtask
   task automatic hdr(input logic [1:0] m, input logic [19:0] id,
      input logic [23:0] n);
      q.delete();
      put(8'hf2, 8);
      put(n, 24);
      put(8'hff, 8);
      fs = q.size();
      put(16'h5fff, 16);
      put(m, 2);
      put(42'h0, 42);
      put(id, 20);
      fend(1'b0);
   endtask
   task automatic dfr(input logic [231:0] d, input logic bad);
      put(2'h1, 2);
      put(d, 232);
      put(6'h00, 6);
      fend(bad);
   endtask
   task automatic afr(input logic [13:0] a);
      put(2'h0, 2);
      put(a, 14);
      fend(1'b0);
   endtask
   task automatic send(input logic postamble);
      if (postamble) put(40'h3fffffffff, 40);
      foreach (q[i]) u_src.tx(q[i]);
      repeat (8) @(posedge clk);
   endtask
   task automatic rst();
      sys_rst <= 1'b1;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge clk);
      wa.delete();
      wq.delete();
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s);
      logic ok;
      awa <= a;
      wd <= d;
      ws <= s;
      awv <= 1'b1;
      wv <= 1'b1;
      do begin
         @(negedge clk);
         ok = awr;
         @(posedge clk);
      end while (!ok);
      awv <= 1'b0;
      wv <= 1'b0;
      bry <= 1'b1;
      do begin
         @(negedge clk);
         ok = bv;
         @(posedge clk);
      end while (!ok);
      bry <= 1'b0;
   endtask
   task automatic rreg(input logic [7:0] a);
      logic ok;
      ara <= a;
      arv <= 1'b1;
      do begin
         @(negedge clk);
         ok = arr;
         @(posedge clk);
      end while (!ok);
      arv <= 1'b0;
      rry <= 1'b1;
      do begin
         @(negedge clk);
         ok = rv;
         rd = rdat;
         rs = rr;
         @(posedge clk);
      end while (!ok);
      rry <= 1'b0;
   endtask
   task automatic t_auto();
      rst();
      hdr(2'h0, PID, 24'h0002b2);
      dfr(D1, 1'b0);
      dfr(D2, 1'b0);
      send(1'b1);
      chk({done, rdy_n}, 2'h1);
      u_src.tx(1'b1);
      u_src.tx(1'b1);
      repeat (8) @(posedge clk);
      chk(wa.size(), 2);
      chk({wa[0], wa[1]}, {14'h0000, 14'h0001});
      chk({wq[0], wq[1]}, {D1, D2});
      chk({done, rdy_n}, 2'h3);
      rreg(8'h40);
      chk({rd[10:9], rd[2], rd[1], rd[15]}, 5'h06);
      rreg(8'h44);
      chk(rd, 32'h2);
      rreg(8'h48);
      chk(rd, 32'h2b2);
      rreg(8'h4c);
      chk(rd, PID);
      rreg(8'h00);
      chk({rs, rd}, {2'h2, 32'h0});
      $display("auto load test done");
   endtask
   task automatic t_expl();
      rst();
      hdr(2'h1, PID, 24'h000001);
      dfr(D1, 1'b0);
      afr(14'h0005);
      afr(14'h0009);
      send(1'b1);
      chk(wa.size(), 2);
      chk({wa[0], wa[1]}, {14'h0005, 14'h0009});
      chk({wq[0], wq[1]}, {D1, D1});
      rreg(8'h40);
      chk({rd[15], rd[1]}, 2'h3);
      $display("explicit load test done");
   endtask
   task automatic t_err(input int k);
      rst();
      hdr(2'h0, k == 0 ? PID ^ 20'h00001 : PID, 24'h000001);
      if (k == 2) q[q.size() - 4] = 1'b0;
      if (k != 0) dfr(D1, k == 1);
      send(1'b0);
      chk(rdy_n, 1'b0);
      chk(wa.size(), 0);
      rreg(8'h40);
      chk(rd[10:9], k == 0 ? ERR_ID : k == 1 ? ERR_CSUM : ERR_ALIGN);
      chk(rd[3], 1'b1);
      u_src.tx(1'b1);
      repeat (8) @(posedge clk);
      chk(rdy_n, 1'b0);
      if (k == 1) begin
         rpq <= 1'b1;
         repeat (8) @(posedge clk);
         rpq <= 1'b0;
      end else wreg(8'h40, 32'h1008, 4'h3);
      repeat (8) @(posedge clk);
      chk(rdy_n, 1'b1);
      rreg(8'h40);
      chk(rd[10:9], ERR_NONE);
      chk(rd[3], k == 1);
      $display("error test done");
   endtask
   task automatic results();
      $display("compares %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      {sys_rst, rpq, awv, wv, bry, arv, rry} = 7'h40;
      {awa, ara, wd, ws} = 52'h0;
      {n_errors, cmp_count, cyc, fs} = 128'h0;
      t_auto();
      t_expl();
      for (int k = 0; k < 3; k++) t_err(k);
      results();
   end
endmodule // config_bitstream_frame_checker_test
